// [hdl/ccsp_pkg.sv]
package ccsp_pkg;

  // Instruction bytes seen as the first byte after select falls.
  localparam logic [7:0] INS_RESET = 8'hc0;
  localparam logic [7:0] INS_READ = 8'h03;
  localparam logic [7:0] INS_WRITE = 8'h02;
  localparam logic [7:0] INS_QSTAT = 8'ha0;
  localparam logic [7:0] INS_RXSTAT = 8'hb0;
  localparam logic [7:0] INS_LOAD_TX = 8'h40;
  localparam logic [7:0] INS_RTS = 8'h80;
  localparam logic [7:0] INS_READ_RX = 8'h90;

  // Masks that strip the variant bits from the shortcut instructions.
  localparam logic [7:0] MASK_VAR3 = 8'hf8;
  localparam logic [7:0] MASK_RX_VAR = 8'hf9;

  // Load-transmit variants at or above this value select no location.
  localparam logic [2:0] TX_SEL_LIMIT = 3'h6;

  // Fixed pointer targets of the shortcut instructions.
  localparam logic [7:0] TXB0_ID_ADDR = 8'h31;
  localparam logic [7:0] RXB0_ID_ADDR = 8'h61;
  localparam logic [7:0] BUF_DATA_OFS = 8'h05;

  // Bit counter value of the last bit in a byte.
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Write queue shape: pointer byte above data byte.
  localparam int WQ_WIDTH = 16;
  localparam int WQ_DEPTH = 16;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR_RD,
    ST_ADDR_WR,
    ST_RD_DATA,
    ST_WR_DATA,
    ST_STAT_Q,
    ST_STAT_RX,
    ST_IGNORE
  } ccsp_state_t;

endpackage

// [hdl/ccsp_spi_cmd_port.sv]
// Notes on behaviour
// R1: Works as SPI slave in modes 0,0 and 1,1.
// R2: Input bits are sampled on SCK rising edges.
// R3: Output bits change on SCK falling edges.
// R4: Host keeps select low for the whole of each operation.
// R5: First byte after select falls is the instruction; new instruction needs reselect.
// R6: Reset instruction restores all registers and enters configuration mode.
// R7: Host sends reset as a lone byte between select edges.
// R8: Host should reset the device during power-on initialisation.
// R9: Read sends instruction and 8-bit address MSB first; device returns register.
// R10: Read pointer advances per byte; read continues until select rises.
// R11: Receive-buffer read has four variants preloading the pointer; then reads sequentially.
// R12: Select rise after receive-buffer read clears that buffer's receive-full flag.
// R13: Write sends address then data bytes to successive registers.
// R14: Each write byte commits on the rising edge sampling its last bit; a byte meeting a full write queue is dropped.
// R15: A partial write byte at select rise is dropped; earlier bytes stay.
// R16: Transmit-buffer load preloads one of six identifier or data locations.
// R17: Request-to-send sets the request bit of each selected transmit buffer.
// R18: Request-to-send with all selects zero does nothing.
// R19: Quick status word is shifted out and repeated while clocked.
// R20: Receive status byte is shifted out and repeated while clocked.
// R21: Quick status bits are also readable by normal register read.
// R22: Encodings: reset c0, read 03, write 02.
// R23: Encodings: quick status a0, receive status b0, load transmit 40 plus select.
// R24: Request-to-send 80 plus selects; receive-buffer read 90 with bits 2 and 1.
// R25: Unknown instructions are ignored until select rises; output stays idle.
`timescale 1ns/1ps
`default_nettype none

module ccsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // Full when the pointers differ only in the wrap bit.
  assign in_ready = (wr_ptr_r != {~rd_ptr_r[AW], rd_ptr_r[AW-1:0]});
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; only the pointers decide what is valid.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointer movement.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

module ccsp_spi_cmd_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic [7:0] quick_status,
  input wire logic [7:0] rx_status,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_raddr,
  input wire logic reg_wr_ready,
  output logic reg_we,
  output logic [7:0] reg_waddr,
  output logic [7:0] reg_wdata,
  output logic [2:0] transmit_request_bit_set,
  output logic [1:0] receive_full_flag_clr,
  output logic soft_reset,
  output logic wr_overflow
);
  logic cs_m_r, cs_s_r, cs_d_r;
  logic sck_m_r, sck_s_r, sck_d_r;
  logic si_m_r, si_s_r;
  logic sel, sck_rise, sck_fall, cs_rise;
  logic [2:0] bit_cnt_r;
  logic [6:0] sh_in_r;
  logic [7:0] sh_out_r;
  logic byte_done;
  logic [7:0] byte_in;
  ccsp_pkg::ccsp_state_t state_r;
  logic [7:0] ptr_r;
  logic rx_buf_r;
  logic rx_read_r;
  logic [7:0] out_src;
  logic push_valid, wq_in_ready, wq_out_valid, wq_out_ready;
  logic [15:0] wq_out_data;
  logic so_r, so_oe_r, we_r, soft_reset_r, overflow_r;
  logic [7:0] raddr_r, waddr_r, wdata_r;
  logic [2:0] tx_request_r;
  logic [1:0] rxclr_r;

  // Pins come from the host's domain; each passes two flops before use.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      si_m_r <= 1'b0;
      si_s_r <= 1'b0;
    end else begin
      cs_m_r <= spi_cs_n;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
      sck_m_r <= spi_sck;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      si_m_r <= spi_si;
      si_s_r <= si_m_r;
    end
  end

  // Edges are found on the oversampled clock, so idle level does not matter.
  assign sel = ~cs_s_r;
  assign sck_rise = sel & sck_s_r & ~sck_d_r; // R1
  assign sck_fall = sel & ~sck_s_r & sck_d_r; // R1
  assign cs_rise = cs_s_r & ~cs_d_r;
  assign byte_done = sck_rise & (bit_cnt_r == ccsp_pkg::LAST_BIT);
  assign byte_in = {sh_in_r, si_s_r};

  // Input shifter; a deselect wipes any partial byte.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_r <= '0;
      sh_in_r <= '0;
    end else if (!sel) begin
      bit_cnt_r <= '0; // R15
    end else if (sck_rise) begin
      sh_in_r <= byte_in[6:0]; // R2
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // Command sequencer; every selection restarts at the instruction byte.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ccsp_pkg::ST_CMD;
      ptr_r <= '0;
      rx_buf_r <= 1'b0;
      rx_read_r <= 1'b0;
    end else if (!sel) begin
      state_r <= ccsp_pkg::ST_CMD; // R5
      rx_read_r <= 1'b0;
    end else if (byte_done) begin
      case (state_r)
        ccsp_pkg::ST_CMD: begin
          if (byte_in == ccsp_pkg::INS_READ) begin // R22
            state_r <= ccsp_pkg::ST_ADDR_RD;
          end else if (byte_in == ccsp_pkg::INS_WRITE) begin
            state_r <= ccsp_pkg::ST_ADDR_WR;
          end else if (byte_in == ccsp_pkg::INS_QSTAT) begin // R23
            state_r <= ccsp_pkg::ST_STAT_Q;
          end else if (byte_in == ccsp_pkg::INS_RXSTAT) begin
            state_r <= ccsp_pkg::ST_STAT_RX;
          end else if ((byte_in & ccsp_pkg::MASK_RX_VAR) == ccsp_pkg::INS_READ_RX) begin // R24
            ptr_r <= ccsp_pkg::RXB0_ID_ADDR + {3'b000, byte_in[2], 4'h0}
                     + (byte_in[1] ? ccsp_pkg::BUF_DATA_OFS : 8'h00); // R11
            rx_buf_r <= byte_in[2];
            rx_read_r <= 1'b1;
            state_r <= ccsp_pkg::ST_RD_DATA;
          end else if ((byte_in & ccsp_pkg::MASK_VAR3) == ccsp_pkg::INS_LOAD_TX
                       && byte_in[2:0] < ccsp_pkg::TX_SEL_LIMIT) begin
            ptr_r <= ccsp_pkg::TXB0_ID_ADDR + {2'b00, byte_in[2:1], 4'h0}
                     + (byte_in[0] ? ccsp_pkg::BUF_DATA_OFS : 8'h00); // R16
            state_r <= ccsp_pkg::ST_WR_DATA;
          end else begin
            // Reset, request-to-send and unknown bytes take no further bytes.
            state_r <= ccsp_pkg::ST_IGNORE; // R25
          end
        end
        ccsp_pkg::ST_ADDR_RD: begin
          ptr_r <= byte_in; // R9
          state_r <= ccsp_pkg::ST_RD_DATA;
        end
        ccsp_pkg::ST_ADDR_WR: begin
          ptr_r <= byte_in; // R13
          state_r <= ccsp_pkg::ST_WR_DATA;
        end
        ccsp_pkg::ST_RD_DATA: begin
          ptr_r <= ptr_r + 8'h01; // R10
        end
        ccsp_pkg::ST_WR_DATA: begin
          ptr_r <= ptr_r + 8'h01; // R13
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Read port address follows the pointer; register file answers next cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      raddr_r <= '0;
    end else begin
      raddr_r <= ptr_r;
    end
  end

  // Byte to send next, chosen by the phase of the command.
  always_comb begin
    out_src = 8'h00;
    case (state_r)
      ccsp_pkg::ST_RD_DATA: out_src = reg_rdata; // R9 R21
      ccsp_pkg::ST_STAT_Q: out_src = quick_status; // R19
      ccsp_pkg::ST_STAT_RX: out_src = rx_status; // R20
      default: out_src = 8'h00;
    endcase
  end

  // Output shifter. A new byte is loaded on the one falling edge per byte
  // that meets a zero bit count, which holds in both clock modes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
      sh_out_r <= '0;
    end else if (!sel) begin
      so_oe_r <= 1'b0;
    end else if (sck_fall) begin
      if (state_r == ccsp_pkg::ST_RD_DATA || state_r == ccsp_pkg::ST_STAT_Q
          || state_r == ccsp_pkg::ST_STAT_RX) begin
        so_oe_r <= 1'b1;
        if (bit_cnt_r == 3'h0) begin
          so_r <= out_src[7]; // R3
          sh_out_r <= {out_src[6:0], 1'b0};
        end else begin
          so_r <= sh_out_r[7]; // R3
          sh_out_r <= {sh_out_r[6:0], 1'b0};
        end
      end else begin
        so_oe_r <= 1'b0; // R25
      end
    end
  end

  // Whole write bytes only; a partial byte never reaches the queue.
  assign push_valid = byte_done & (state_r == ccsp_pkg::ST_WR_DATA); // R14

  // The queue absorbs bursts while the register file is busy.
  ccsp_fifo #(
    .WIDTH(ccsp_pkg::WQ_WIDTH),
    .DEPTH(ccsp_pkg::WQ_DEPTH)
  ) u_wq (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_valid),
    .in_ready(wq_in_ready),
    .in_data({ptr_r, byte_in}),
    .out_valid(wq_out_valid),
    .out_ready(wq_out_ready),
    .out_data(wq_out_data)
  );

  // The host cannot be stalled mid-byte, so a full queue drops the byte and
  // leaves a sticky flag until reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_r <= 1'b0;
    end else if (push_valid && !wq_in_ready) begin
      overflow_r <= 1'b1;
    end
  end

  // Drain: one write strobe per entry, held off by the register file.
  assign wq_out_ready = reg_wr_ready & ~we_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      we_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
    end else begin
      we_r <= wq_out_valid & wq_out_ready;
      if (wq_out_valid && wq_out_ready) begin
        waddr_r <= wq_out_data[15:8];
        wdata_r <= wq_out_data[7:0];
      end
    end
  end

  // One-cycle action pulses toward the rest of the controller.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_r <= 1'b0;
      tx_request_r <= '0;
      rxclr_r <= '0;
    end else begin
      soft_reset_r <= byte_done && state_r == ccsp_pkg::ST_CMD
                      && byte_in == ccsp_pkg::INS_RESET; // R6
      tx_request_r <= '0;
      if (byte_done && state_r == ccsp_pkg::ST_CMD
          && (byte_in & ccsp_pkg::MASK_VAR3) == ccsp_pkg::INS_RTS) begin
        tx_request_r <= byte_in[2:0]; // R17 R18
      end
      rxclr_r <= '0;
      if (cs_rise && rx_read_r) begin
        rxclr_r <= rx_buf_r ? 2'b10 : 2'b01; // R12
      end
    end
  end

  assign spi_so = so_r;
  assign spi_so_oe = so_oe_r;
  assign reg_raddr = raddr_r;
  assign reg_we = we_r;
  assign reg_waddr = waddr_r;
  assign reg_wdata = wdata_r;
  assign transmit_request_bit_set = tx_request_r;
  assign receive_full_flag_clr = rxclr_r;
  assign soft_reset = soft_reset_r;
  assign wr_overflow = overflow_r;

  property p_rts_set;
    @(posedge clk) disable iff (!arst_n)
    byte_done && state_r == ccsp_pkg::ST_CMD && byte_in[7:3] == 5'h10
    |=> transmit_request_bit_set == $past(byte_in[2:0]);
  endproperty
  a_rts_set: assert property (p_rts_set) else $error("request bits wrong"); // R17

  property p_rts_none;
    @(posedge clk) disable iff (!arst_n)
    byte_done && state_r == ccsp_pkg::ST_CMD && byte_in == 8'h80
    |=> transmit_request_bit_set == 3'h0 ##1 transmit_request_bit_set == 3'h0;
  endproperty
  a_rts_none: assert property (p_rts_none) else $error("empty request acted"); // R18

  property p_reset_pulse;
    @(posedge clk) disable iff (!arst_n)
    byte_done && state_r == ccsp_pkg::ST_CMD && byte_in == 8'hc0
    |=> soft_reset ##1 !soft_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse wrong"); // R6

  property p_rx_clear;
    @(posedge clk) disable iff (!arst_n)
    cs_rise && rx_read_r |=> receive_full_flag_clr == ($past(rx_buf_r) ? 2'b10 : 2'b01);
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive flag not cleared"); // R12

  property p_no_clear;
    @(posedge clk) disable iff (!arst_n)
    !(cs_rise && rx_read_r) |=> receive_full_flag_clr == 2'b00;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("stray receive clear"); // R12

  property p_wr_commit;
    @(posedge clk) disable iff (!arst_n)
    byte_done && state_r == ccsp_pkg::ST_WR_DATA && wq_in_ready
    |=> wq_out_valid && ptr_r == $past(ptr_r) + 8'h01;
  endproperty
  a_wr_commit: assert property (p_wr_commit) else $error("write byte not committed"); // R14

  property p_partial_drop;
    @(posedge clk) disable iff (!arst_n)
    !sel |-> !push_valid ##1 bit_cnt_r == 3'h0;
  endproperty
  a_partial_drop: assert property (p_partial_drop) else $error("partial byte kept"); // R15

  property p_so_on_fall;
    @(posedge clk) disable iff (!arst_n)
    sel && $changed(so_r) |-> $past(sck_fall);
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) else $error("output moved off falling edge"); // R3

  property p_ignore_idle;
    @(posedge clk) disable iff (!arst_n)
    state_r == ccsp_pkg::ST_IGNORE && sck_fall |=> !spi_so_oe;
  endproperty
  a_ignore_idle: assert property (p_ignore_idle) else $error("output driven when ignoring"); // R25

  property p_reselect;
    @(posedge clk) disable iff (!arst_n)
    !sel |=> state_r == ccsp_pkg::ST_CMD;
  endproperty
  a_reselect: assert property (p_reselect) else $error("no restart at instruction"); // R5

  property p_status_load;
    @(posedge clk) disable iff (!arst_n)
    state_r == ccsp_pkg::ST_STAT_Q && sck_fall && bit_cnt_r == 3'h0
    |=> spi_so == $past(quick_status[7]) && spi_so_oe;
  endproperty
  a_status_load: assert property (p_status_load) else $error("status word not sent"); // R19
endmodule

`default_nettype wire

// [verif/ccsp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ccsp_host_model (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si
);
  logic [7:0] tx [0:31];
  logic [7:0] rx [0:31];
  logic oe_seen;

  // The link is idle and deselected until the first frame.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    oe_seen = 1'b0;
  end

  // Each link clock level lasts four system clocks, half of the 200 ns period.
  task automatic hold4();
    repeat (4) @(negedge clk);
  endtask

  // One frame: select, shift nbits out MSB first, deselect. SCK idles at cpol.
  task automatic run(input logic cpol, input int nbits);
    int i;
    oe_seen = 1'b0;
    @(negedge clk);
    sck <= cpol;
    hold4();
    cs_n <= 1'b0;
    hold4();
    for (i = 0; i < nbits; i++) begin
      sck <= 1'b0;
      si <= tx[i / 8][7 - (i % 8)];
      hold4();
      rx[i / 8][7 - (i % 8)] = so;
      oe_seen = oe_seen | (so_oe === 1'b1);
      sck <= 1'b1;
      hold4();
    end
    sck <= cpol;
    hold4();
    cs_n <= 1'b1;
    // A released data line must not keep showing the last bit.
    si <= ~si;
    repeat (8) @(negedge clk);
  endtask
endmodule

`default_nettype wire

// [verif/can_ctrl_spi_command_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module can_ctrl_spi_command_port_bench;
  logic clk, arst_n, stall, cs_n, sck, si, so, so_oe, reg_wr_ready, reg_we, soft_reset;
  logic wr_overflow;
  logic [7:0] quick_status, rx_status, reg_rdata, reg_raddr, reg_waddr, reg_wdata, a, st;
  logic [2:0] req_set;
  logic [1:0] flag_clr;
  logic [7:0] mem [0:255];
  logic [15:0] wr_q [$];
  logic [2:0] req_q [$];
  logic [1:0] clr_q [$];
  logic rst_q [$];
  int err_total, checks_done;

  ccsp_spi_cmd_port i_dut (.clk(clk), .arst_n(arst_n), .spi_cs_n(cs_n), .spi_sck(sck),
    .spi_si(si), .spi_so(so), .spi_so_oe(so_oe), .quick_status(quick_status),
    .rx_status(rx_status), .reg_rdata(reg_rdata), .reg_raddr(reg_raddr),
    .reg_wr_ready(reg_wr_ready), .reg_we(reg_we), .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata), .transmit_request_bit_set(req_set),
    .receive_full_flag_clr(flag_clr), .soft_reset(soft_reset), .wr_overflow(wr_overflow));

  ccsp_host_model i_host (.clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));

  // The register file answers at once, well inside the one cycle the port allows.
  assign reg_rdata = mem[reg_raddr];

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Random stalls keep the write queue busy; a test may hold them for a whole frame.
  always @(negedge clk) reg_wr_ready <= stall ? 1'b0 : 1'($urandom % 2);

  task automatic bad(input string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) bad($sformatf("read %h expected %h", got, exp));
  endtask

  task automatic cmp_wr(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) bad($sformatf("write %h expected %h", got, exp));
  endtask

  task automatic cmp_pls(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) bad($sformatf("pulse %b expected %b", got, exp));
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) bad($sformatf("flag %b expected %b", got, exp));
  endtask

  // Each strobe takes the oldest note of its kind; a strobe with no note is an error.
  // Outputs are looked at on the falling edge, half a cycle after they settle.
  always @(negedge clk) begin
    if (arst_n === 1'b1 && reg_we === 1'b1) begin
      mem[reg_waddr] <= reg_wdata;
      if (wr_q.size() == 0) bad("write not expected");
      else cmp_wr({reg_waddr, reg_wdata}, wr_q.pop_front());
    end
    if (arst_n === 1'b1 && req_set !== 3'h0) begin
      if (req_q.size() == 0) bad("send request not expected");
      else cmp_pls(req_set, req_q.pop_front());
    end
    if (arst_n === 1'b1 && flag_clr !== 2'h0) begin
      if (clr_q.size() == 0) bad("flag clear not expected");
      else cmp_pls({1'b0, flag_clr}, {1'b0, clr_q.pop_front()});
    end
    if (arst_n === 1'b1 && soft_reset !== 1'b0) begin
      if (rst_q.size() == 0) bad("soft reset not expected");
      else cmp_flag(soft_reset, rst_q.pop_front());
    end
  end

  // Every noted result must have shown up once the link has gone quiet.
  task automatic done(input string name);
    repeat (100) @(negedge clk);
    cmp_flag(wr_q.size() + req_q.size() + clr_q.size() + rst_q.size() == 0, 1'b1);
    $display("test %s done", name);
  endtask

  // Shortcut targets: buffers sit 10h apart, the data field five past the start.
  function automatic logic [7:0] target(input logic [7:0] base, input int k);
    return base + 8'h10 * 8'(k / 2) + ((k % 2) ? ccsp_pkg::BUF_DATA_OFS : 8'h00);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Twenty-eight frames of under two thousand cycles; far beyond that is a hang.
  initial begin
    repeat (90000) @(posedge clk);
    bad("timeout");
    summarize();
  end

  // Main sequence, one test per instruction family.
  initial begin
    int i, k;
    arst_n = 1'b0;
    stall = 1'b0;
    err_total = 0;
    checks_done = 0;
    quick_status = 8'h00;
    rx_status = 8'h00;
    for (i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    void'($urandom(32'h30d7));
    repeat (12) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    i_host.tx[0] = ccsp_pkg::INS_RESET;
    rst_q.push_back(1'b1);
    i_host.run(1'b0, 8);
    done("reset");
    // Burst write with a torn last byte: only whole bytes may land.
    a = 8'($urandom);
    i_host.tx[0] = ccsp_pkg::INS_WRITE;
    i_host.tx[1] = a;
    for (i = 0; i < 4; i++) begin
      i_host.tx[2 + i] = 8'($urandom);
      if (i < 3) wr_q.push_back({a + 8'(i), i_host.tx[2 + i]});
    end
    i_host.run(1'b1, 45);
    done("write");
    for (k = 0; k < 2; k++) begin
      i_host.tx[0] = ccsp_pkg::INS_READ;
      i_host.tx[1] = a;
      i_host.run(k[0], 40);
      for (i = 0; i < 3; i++) cmp_rd(i_host.rx[2 + i], mem[8'(a + i)]);
    end
    done("read");
    // The two spare load codes must write nothing.
    for (k = 0; k < 8; k++) begin
      i_host.tx[0] = ccsp_pkg::INS_LOAD_TX | 8'(k);
      i_host.tx[1] = 8'($urandom);
      if (k < 6) wr_q.push_back({target(ccsp_pkg::TXB0_ID_ADDR, k), i_host.tx[1]});
      i_host.run(k[0], 16);
    end
    done("load");
    for (k = 0; k < 4; k++) begin
      i_host.tx[0] = ccsp_pkg::INS_READ_RX | 8'(k << 1);
      st = target(ccsp_pkg::RXB0_ID_ADDR, k);
      clr_q.push_back(2'(1 << (k / 2)));
      i_host.run(k[0], 24);
      cmp_rd(i_host.rx[1], mem[st]);
      cmp_rd(i_host.rx[2], mem[8'(st + 1)]);
    end
    done("rx read");
    for (k = 0; k < 8; k++) begin
      i_host.tx[0] = ccsp_pkg::INS_RTS | 8'(k);
      if (k != 0) req_q.push_back(3'(k));
      i_host.run(k[0], 8);
    end
    done("send request");
    for (k = 0; k < 2; k++) begin
      quick_status = 8'($urandom);
      rx_status = 8'($urandom);
      st = k ? rx_status : quick_status;
      i_host.tx[0] = k ? ccsp_pkg::INS_RXSTAT : ccsp_pkg::INS_QSTAT;
      i_host.run(k[0], 24);
      cmp_rd(i_host.rx[1], st);
      cmp_rd(i_host.rx[2], st);
      cmp_flag(i_host.oe_seen, 1'b1);
    end
    done("status");
    // Bit modify is not served by this port: no output and no write.
    i_host.tx[0] = 8'h05;
    i_host.run(1'b0, 32);
    cmp_flag(i_host.oe_seen, 1'b0);
    done("unknown");
    // Fill the write queue against a stalled register file; extra bytes are lost.
    cmp_flag(wr_overflow, 1'b0);
    stall = 1'b1;
    i_host.tx[0] = ccsp_pkg::INS_WRITE;
    i_host.tx[1] = 8'h80;
    for (i = 0; i < 18; i++) begin
      i_host.tx[2 + i] = 8'($urandom);
      if (i < ccsp_pkg::WQ_DEPTH) wr_q.push_back({8'h80 + 8'(i), i_host.tx[2 + i]});
    end
    i_host.run(1'b0, 160);
    cmp_flag(wr_overflow, 1'b1);
    stall = 1'b0;
    done("overflow");
    summarize();
  end
endmodule

`default_nettype wire
